//--- src/dimming_defines.vh
// Constants for the one-wire dimming front end: timing figures, command layout, reset values.
// Assumes a single core clock whose rate in MHz is given below; cycle counts derive from it.
`ifndef DIMMING_DEFINES_VH
`define DIMMING_DEFINES_VH

// Core clock rate in MHz
`define CLK_MHZ 21'h64

// Start-up detection timing, in microseconds; sized to the counter so products keep that width
`define DETECT_DELAY_US 21'h64
`define DETECT_LOW_HOLD_US 21'h104
`define DETECT_WINDOW_US 21'h3E8

// Shutdown timing, in microseconds
`define CHIP_ON_OFF_US 21'h9C4
`define PWM_OFF_US 21'h4E20

// Longest single low or high phase of a command bit (slowest rate is about 588 us a bit)
`define BIT_PHASE_MAX_US 21'h258

// Length of the acknowledge pull-down, in microseconds
`define ACK_HOLD_US 21'h200

// Counter width, wide enough for the 20 ms count
`define CNT_W 21

// Command layout: 24 bits sent LSB first, address byte on top
`define CMD_BITS 24
`define BIT_CNT_W 5
`define ADDR_MSB 23
`define ADDR_LSB 16
`define ACK_FLAG_BIT 10
`define CODE_MSB 8

// Brightness code reset value and full-scale level
`define CODE_W 9
`define CODE_RESET 9'h1FF
`define LEVEL_FULL 9'h1FF

// Duty division steps, one per result bit
`define DIV_STEPS 4'h9

`endif

//--- src/one_wire_dimming_interface.v
// Digital front end of a dual-channel backlight driver: start-up interface detection,
// one-wire command receiver with acknowledge, PWM duty measurement, enable/shutdown timing.
// Assumes CHIP_ON_PIN, PWM_PIN and SUPPLY_OK are asynchronous to CLK; the pin pull-down
// is resolved outside from ACK_PULL_O / ACK_PULL_OE (open drain).
//
// Summary of operation
// - Low-hold within 1 ms window selects one-wire mode
// - Interface chosen anew at every start from shutdown
// - Nine-bit brightness code starts at all ones
// - Shutdown or disable returns code to all ones
// - One-wire current equals full scale times code/511
// - PWM tied high: chip-on low 2.5 ms disables
// - Both GPIOs: chip-on 2.5 ms or PWM 20 ms
// - No pattern detected selects PWM mode
// - PWM mode: PWM low over 20 ms disables
// - Start only after chip-on and PWM both applied
// - Constant high PWM gives full-scale current
// - PWM mode current follows measured duty cycle
// - Command accepted only on matching address byte
// - Data field holds code and acknowledge request
// - Acknowledge only for correctly received commands
// - Bit decoder follows 1.7 to 160 kbit/s
// - Acknowledge flag bit 10 pulls line low
// - Code occupies data bits 8 down to 0
`timescale 1ns/1ps
`include "dimming_defines.vh"

module one_wire_dimming_interface #(
  // Own address code; this value is arbitrary
  parameter [7:0] DEVICE_ADDRESS = 8'hA5,
  parameter [`CNT_W-1:0] DETECT_DELAY_CYC = `DETECT_DELAY_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] DETECT_LOW_HOLD_CYC = `DETECT_LOW_HOLD_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] DETECT_WINDOW_CYC = `DETECT_WINDOW_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] CHIP_ON_OFF_CYC = `CHIP_ON_OFF_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] PWM_OFF_CYC = `PWM_OFF_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] BIT_PHASE_MAX_CYC = `BIT_PHASE_MAX_US * `CLK_MHZ,
  parameter [`CNT_W-1:0] ACK_HOLD_CYC = `ACK_HOLD_US * `CLK_MHZ
) (
  input wire CLK,
  input wire RESETN,
  input wire SUPPLY_OK,
  input wire CHIP_ON_PIN,
  input wire PWM_PIN,
  output wire ACK_PULL_O,
  output wire ACK_PULL_OE,
  output wire DEVICE_ENABLED,
  output wire ONE_WIRE_MODE,
  output wire PWM_MODE,
  output wire [`CODE_W-1:0] BRIGHTNESS_CODE,
  output wire [`CODE_W-1:0] CURRENT_LEVEL,
  output wire CMD_REJECTED
);

  // One-hot start-up and mode states
  localparam [4:0] ST_OFF = 5'h01;
  localparam [4:0] ST_DETECT = 5'h02;
  localparam [4:0] ST_ONE_WIRE = 5'h04;
  localparam [4:0] ST_PWM = 5'h08;

  reg [2:0] sync1_r; // First synchroniser stage
  reg [2:0] sync2_r; // Second stage: supply, chip-on, pwm
  reg on_prev_r; // Chip-on level one cycle back
  reg pwm_prev_r; // PWM level one cycle back
  wire supply_s = sync2_r[0];
  wire on_s = sync2_r[1];
  wire pwm_s = sync2_r[2];
  wire on_rise = on_s & ~on_prev_r;
  wire on_fall = ~on_s & on_prev_r;
  wire pwm_rise = pwm_s & ~pwm_prev_r;
  wire pwm_fall = ~pwm_s & pwm_prev_r;

  reg [4:0] st_r; // Current state
  reg [4:0] st_nxt; // Next state
  reg [`CNT_W-1:0] win_cnt_r; // Cycles since the detection window opened
  reg [`CNT_W-1:0] det_low_r; // Chip-on low time after the detection delay
  reg [`CNT_W-1:0] on_low_r; // Chip-on low phase length, saturating
  reg [`CNT_W-1:0] on_high_r; // Chip-on high phase length, saturating
  reg [`CNT_W-1:0] pwm_low_r; // PWM low phase length, saturating
  reg [`CNT_W-1:0] pwm_high_r; // PWM high phase length, saturating
  reg [`CNT_W-1:0] pwm_per_r; // Cycles since last PWM rising edge
  reg [`CNT_W-1:0] hi_len_r; // Last complete PWM high phase
  reg per_valid_r; // A previous PWM rising edge has been seen

  reg [`CNT_W-1:0] low_len_r; // Low phase of the bit in progress
  reg armed_r; // A valid low phase awaits its high phase
  reg [`BIT_CNT_W-1:0] bit_cnt_r; // Bits collected in this frame
  reg [`CMD_BITS-1:0] shift_r; // Received bits, first bit ends in bit 0
  reg [`CODE_W-1:0] code_r; // Stored brightness code
  reg ack_pend_r; // Acknowledge waits for the line to rise
  reg ack_r; // Pulling the line low
  reg ack_drop_r; // Own pull released, next rise is not a bit
  reg [`CNT_W-1:0] ack_cnt_r; // Pull-down duration
  reg reject_r; // Pulse on a malformed or foreign command

  reg [`CNT_W+1:0] rem_r; // Division remainder
  reg [`CNT_W-1:0] div_r; // Division divisor, the period
  reg [3:0] step_r; // Division steps left
  reg [`CODE_W:0] quo_r; // Division quotient
  reg [`CODE_W-1:0] duty_r; // Measured duty as a level of 511
  reg [`CODE_W-1:0] level_r; // Current level to the sinks
  reg en_r; // Device enabled

  // Bit decision and the full frame it would complete
  wire bit_val = on_high_r > low_len_r;
  wire bit_tie = on_high_r == low_len_r;
  wire [`CMD_BITS-1:0] frame = {bit_val, shift_r[`CMD_BITS-1:1]};
  wire frame_done = bit_cnt_r == (`CMD_BITS - 1);
  wire ack_busy = ack_pend_r | ack_r | ack_drop_r;
  wire off_req = ~supply_s | (on_low_r > CHIP_ON_OFF_CYC) | (pwm_low_r > PWM_OFF_CYC);
  wire div_ge = {rem_r[`CNT_W:0], 1'b0} >= {2'b00, div_r}; // Next quotient bit
  wire [`CODE_W:0] quo_next = {quo_r[`CODE_W-1:0], div_ge}; // Quotient after this step

  // Two-flop synchronisers for all asynchronous inputs
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      on_prev_r <= 1'b0;
      pwm_prev_r <= 1'b0;
    end else begin
      sync1_r <= {PWM_PIN, CHIP_ON_PIN, SUPPLY_OK};
      sync2_r <= sync1_r;
      on_prev_r <= on_s;
      pwm_prev_r <= pwm_s;
    end
  end

  // Next state: detection, mode choice and shutdown
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF: begin
        // Both inputs applied above lockout opens the window
        if (supply_s && on_s && pwm_s) begin
          st_nxt = ST_DETECT;
        end
      end
      ST_DETECT: begin
        if (off_req) begin
          st_nxt = ST_OFF;
        end else if (win_cnt_r >= DETECT_WINDOW_CYC) begin
          st_nxt = ST_PWM;
        end else if (det_low_r > DETECT_LOW_HOLD_CYC) begin
          st_nxt = ST_ONE_WIRE;
        end
      end
      ST_ONE_WIRE, ST_PWM: begin
        // Chip-on low 2.5 ms or PWM low 20 ms shuts down
        if (off_req) begin
          st_nxt = ST_OFF;
        end
      end
      default: begin
        st_nxt = ST_OFF;
      end
    endcase
  end

  // State register; every return to off forces a new detection
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= ST_OFF;
      en_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      en_r <= (st_nxt == ST_ONE_WIRE) | (st_nxt == ST_PWM);
    end
  end

  // Detection window and low-hold counters
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      win_cnt_r <= {`CNT_W{1'b0}};
      det_low_r <= {`CNT_W{1'b0}};
    end else if (st_r != ST_DETECT) begin
      win_cnt_r <= {`CNT_W{1'b0}};
      det_low_r <= {`CNT_W{1'b0}};
    end else begin
      win_cnt_r <= win_cnt_r + 1'b1;
      // Low time only counts once the detection delay is over
      if (on_s || win_cnt_r < DETECT_DELAY_CYC) begin
        det_low_r <= {`CNT_W{1'b0}};
      end else begin
        det_low_r <= det_low_r + 1'b1;
      end
    end
  end

  // Phase length counters for both inputs, saturating
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      on_low_r <= {`CNT_W{1'b0}};
      on_high_r <= {`CNT_W{1'b0}};
      pwm_low_r <= {`CNT_W{1'b0}};
      pwm_high_r <= {`CNT_W{1'b0}};
    end else begin
      on_low_r <= on_s ? {`CNT_W{1'b0}} : (&on_low_r ? on_low_r : on_low_r + 1'b1);
      on_high_r <= ~on_s ? {`CNT_W{1'b0}} : (&on_high_r ? on_high_r : on_high_r + 1'b1);
      pwm_low_r <= pwm_s ? {`CNT_W{1'b0}} : (&pwm_low_r ? pwm_low_r : pwm_low_r + 1'b1);
      pwm_high_r <= ~pwm_s ? {`CNT_W{1'b0}} : (&pwm_high_r ? pwm_high_r : pwm_high_r + 1'b1);
    end
  end

  // Rate-free bit decoder: each bit is a low then a high phase
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      low_len_r <= {`CNT_W{1'b0}};
      armed_r <= 1'b0;
      bit_cnt_r <= {`BIT_CNT_W{1'b0}};
      shift_r <= {`CMD_BITS{1'b0}};
      code_r <= `CODE_RESET;
      ack_pend_r <= 1'b0;
      reject_r <= 1'b0;
    end else begin
      reject_r <= 1'b0;
      if (st_r != ST_ONE_WIRE) begin
        // Code back to all ones only while off; kept in detection and PWM mode
        if (st_r == ST_OFF) begin
          code_r <= `CODE_RESET;
        end
        armed_r <= 1'b0;
        bit_cnt_r <= {`BIT_CNT_W{1'b0}};
        ack_pend_r <= 1'b0;
      end else if (ack_busy) begin
        // Own pull-down is not a bit; drop any frame state
        armed_r <= 1'b0;
        bit_cnt_r <= {`BIT_CNT_W{1'b0}};
        if (ack_pend_r && on_rise) begin
          ack_pend_r <= 1'b0;
        end
      end else if (on_rise) begin
        // Low phase ends; an over-long low aborts the frame
        low_len_r <= on_low_r;
        armed_r <= on_low_r <= BIT_PHASE_MAX_CYC;
        if (on_low_r > BIT_PHASE_MAX_CYC) begin
          bit_cnt_r <= {`BIT_CNT_W{1'b0}};
        end
      end else if (on_fall) begin
        armed_r <= 1'b0;
        if (!armed_r || on_high_r > BIT_PHASE_MAX_CYC) begin
          // Idle or stale high: this falling edge starts a fresh frame
          bit_cnt_r <= {`BIT_CNT_W{1'b0}};
        end else if (bit_tie) begin
          // Undecidable bit makes the frame malformed
          bit_cnt_r <= {`BIT_CNT_W{1'b0}};
          reject_r <= 1'b1;
        end else if (frame_done) begin
          bit_cnt_r <= {`BIT_CNT_W{1'b0}};
          shift_r <= frame;
          if (frame[`ADDR_MSB:`ADDR_LSB] == DEVICE_ADDRESS) begin
            code_r <= frame[`CODE_MSB:0];
            ack_pend_r <= frame[`ACK_FLAG_BIT];
          end else begin
            reject_r <= 1'b1;
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + 1'b1;
          shift_r <= frame;
        end
      end
    end
  end

  // Acknowledge: after the host ends the frame, pull the line low
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_r <= 1'b0;
      ack_drop_r <= 1'b0;
      ack_cnt_r <= {`CNT_W{1'b0}};
    end else if (st_r != ST_ONE_WIRE) begin
      ack_r <= 1'b0;
      ack_drop_r <= 1'b0;
      ack_cnt_r <= {`CNT_W{1'b0}};
    end else if (ack_pend_r && on_rise) begin
      ack_r <= 1'b1;
      ack_cnt_r <= {`CNT_W{1'b0}};
    end else if (ack_r) begin
      ack_cnt_r <= ack_cnt_r + 1'b1;
      if (ack_cnt_r >= ACK_HOLD_CYC - 1'b1) begin
        ack_r <= 1'b0;
        ack_drop_r <= 1'b1;
      end
    end else if (ack_drop_r && on_rise) begin
      // Line back high after release: decoding resumes
      ack_drop_r <= 1'b0;
    end
  end

  // PWM period and high phase capture
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pwm_per_r <= {`CNT_W{1'b0}};
      hi_len_r <= {`CNT_W{1'b0}};
      per_valid_r <= 1'b0;
    end else if (st_r != ST_PWM) begin
      pwm_per_r <= {`CNT_W{1'b0}};
      per_valid_r <= 1'b0;
    end else begin
      pwm_per_r <= pwm_rise ? {{(`CNT_W-1){1'b0}}, 1'b1} : (&pwm_per_r ? pwm_per_r : pwm_per_r + 1'b1);
      if (pwm_rise) begin
        per_valid_r <= 1'b1;
      end
      if (pwm_fall) begin
        hi_len_r <= pwm_high_r;
      end
    end
  end

  // Serial divider: duty = high / period scaled to 512 steps
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rem_r <= {(`CNT_W+2){1'b0}};
      div_r <= {`CNT_W{1'b0}};
      step_r <= 4'h0;
      quo_r <= {(`CODE_W+1){1'b0}};
      duty_r <= `LEVEL_FULL;
    end else if (st_r != ST_PWM) begin
      step_r <= 4'h0;
      duty_r <= `LEVEL_FULL;
    end else if (pwm_s && pwm_high_r > PWM_OFF_CYC) begin
      // Steady high level means full scale
      step_r <= 4'h0;
      duty_r <= `LEVEL_FULL;
    end else if (pwm_rise && per_valid_r) begin
      rem_r <= {2'b00, hi_len_r};
      div_r <= pwm_per_r;
      quo_r <= {(`CODE_W+1){1'b0}};
      step_r <= `DIV_STEPS;
    end else if (step_r != 4'h0) begin
      // One quotient bit a cycle; only a finished quotient reaches the sinks
      rem_r <= div_ge ? ({rem_r[`CNT_W:0], 1'b0} - {2'b00, div_r}) : {rem_r[`CNT_W:0], 1'b0};
      quo_r <= quo_next;
      step_r <= step_r - 1'b1;
      if (step_r == 4'h1) begin
        // Clamp a full period to the top level
        duty_r <= quo_next[`CODE_W] ? `LEVEL_FULL : quo_next[`CODE_W-1:0];
      end
    end
  end

  // Sink level: code in one-wire mode, duty in PWM mode, zero when off
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      level_r <= {`CODE_W{1'b0}};
    end else if (st_r == ST_ONE_WIRE) begin
      level_r <= code_r;
    end else if (st_r == ST_PWM) begin
      level_r <= duty_r;
    end else begin
      level_r <= {`CODE_W{1'b0}};
    end
  end

  // Outputs straight from flip-flops; the open-drain output level is always low
  assign ACK_PULL_O = 1'b0 & ack_r;
  assign ACK_PULL_OE = ack_r;
  assign DEVICE_ENABLED = en_r;
  assign ONE_WIRE_MODE = st_r[2];
  assign PWM_MODE = st_r[3];
  assign BRIGHTNESS_CODE = code_r;
  assign CURRENT_LEVEL = level_r;
  assign CMD_REJECTED = reject_r;
endmodule // one_wire_dimming_interface

//--- verif/dim_chk_assertions.sv
// Checker for the dimming front end, port level only.
// Assumes ACK_HOLD_CYC matches the value of the bound instance.
`timescale 1ns/1ps
module dim_chk #(
  parameter [20:0] ACK_HOLD_CYC = 21'h0C800
) (
  input wire CLK,
  input wire RESETN,
  input wire PWM_PIN,
  input wire ACK_PULL_O,
  input wire ACK_PULL_OE,
  input wire DEVICE_ENABLED,
  input wire ONE_WIRE_MODE,
  input wire PWM_MODE,
  input wire [8:0] BRIGHTNESS_CODE,
  input wire [8:0] CURRENT_LEVEL,
  input wire CMD_REJECTED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Cycles the pull-down has stood so far
  reg [20:0] ack_cnt_r;
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN)
      ack_cnt_r <= 21'h0;
    else if (ACK_PULL_OE)
      ack_cnt_r <= ack_cnt_r + 21'h1;
    else
      ack_cnt_r <= 21'h0;
  end
  property p_code_off;
    $fell(DEVICE_ENABLED) |-> ##[0:2] BRIGHTNESS_CODE == 9'h1FF;
  endproperty
  a_code_off: assert property (p_code_off) else $error("code not reset on disable");
  property p_ow_level;
    ONE_WIRE_MODE && $past(ONE_WIRE_MODE, 2) |-> CURRENT_LEVEL == $past(BRIGHTNESS_CODE);
  endproperty
  a_ow_level: assert property (p_ow_level) else $error("level differs from code");
  property p_ack_len;
    $fell(ACK_PULL_OE) |-> ack_cnt_r == ACK_HOLD_CYC;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  property p_ack_low;
    ACK_PULL_OE |-> !ACK_PULL_O && ONE_WIRE_MODE;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack drive wrong");
  property p_rej_pulse;
    CMD_REJECTED |=> !CMD_REJECTED;
  endproperty
  a_rej_pulse: assert property (p_rej_pulse) else $error("reject pulse too long");
  property p_rej_keep;
    CMD_REJECTED |=> $stable(BRIGHTNESS_CODE) [*2];
  endproperty
  a_rej_keep: assert property (p_rej_keep) else $error("code moved on reject");
  property p_start_pwm;
    (!DEVICE_ENABLED && !PWM_PIN) [*4] |=> !DEVICE_ENABLED;
  endproperty
  a_start_pwm: assert property (p_start_pwm) else $error("start without pwm");
  property p_pwm_full;
    $rose(PWM_MODE) |-> ##[0:2] CURRENT_LEVEL == 9'h1FF;
  endproperty
  a_pwm_full: assert property (p_pwm_full) else $error("pwm entry not full");
  c_ack: cover property ($fell(ACK_PULL_OE));
  c_rej: cover property (CMD_REJECTED);
  c_pwm: cover property ($rose(PWM_MODE));
endmodule // dim_chk

bind one_wire_dimming_interface dim_chk #(.ACK_HOLD_CYC(ACK_HOLD_CYC)) chk_u (.*);

//--- verif/host_gpio.sv
// Host model: open-drain driver of the chip-on line with pull-up.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module host_gpio (
  input wire clk,
  input wire ack_oe,
  output wire line
);
  reg rel_r = 1'b0; // High while the host releases the line
  // Line low if either side pulls it
  assign line = rel_r & ~ack_oe;
  // Sets the line and keeps it for n edges
  task hold(input reg lvl, input integer n);
    begin
      rel_r <= lvl;
      repeat (n) @(posedge clk);
    end
  endtask
  // First n bits, low bit first; ones have the longer high
  task bits(input reg [23:0] cmd, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        hold(1'b0, cmd[i] ? 4 : 12);
        hold(1'b1, cmd[i] ? 12 : 4);
      end
    end
  endtask
  // Whole command, end low, then an idle high longer than any bit phase, room for the ack
  task frame(input reg [23:0] cmd);
    begin
      bits(cmd, 24);
      hold(1'b0, 8);
      hold(1'b1, 120);
    end
  endtask
  // Rise, wait past the delay, hold low past the hold time
  task detect;
    begin
      hold(1'b1, 40);
      hold(1'b0, 70);
      hold(1'b1, 200);
    end
  endtask
endmodule // host_gpio

//--- verif/tb.sv
// Testbench for the dimming front end with shortened timing.
// Assumes the host model owns the chip-on line.
`timescale 1ns/1ps
`define CHK(w, e, g) begin checks = checks + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
  $display("BAD %s exp %h got %h", w, e, g); end end
module tb;
  reg CLK = 1'b0;
  reg RESETN = 1'b0;
  reg PWM_PIN = 1'b1;
  reg SUPPLY_OK = 1'b1; // Supply above lockout
  wire CHIP_ON_PIN, ACK_PULL_O, ACK_PULL_OE, DEVICE_ENABLED, ONE_WIRE_MODE, PWM_MODE, CMD_REJECTED;
  wire [8:0] BRIGHTNESS_CODE, CURRENT_LEVEL;
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;
  reg ack_seen = 1'b0; // Sticky: pull-down seen
  reg rej_seen = 1'b0; // Sticky: reject pulse seen
  always #5 CLK = ~CLK;
  host_gpio host_u (.clk(CLK), .ack_oe(ACK_PULL_OE), .line(CHIP_ON_PIN));
  // Shortened timing, in clock cycles
  localparam [20:0] dly_cyc = 21'h14, hold_cyc = 21'h32, win_cyc = 21'hC8, on_off_cyc = 21'h1F4,
    pwm_off_cyc = 21'h7D0, bit_max_cyc = 21'h64, ack_cyc = 21'h28;
  one_wire_dimming_interface #(.DETECT_DELAY_CYC(dly_cyc), .DETECT_LOW_HOLD_CYC(hold_cyc),
    .DETECT_WINDOW_CYC(win_cyc), .CHIP_ON_OFF_CYC(on_off_cyc), .PWM_OFF_CYC(pwm_off_cyc),
    .BIT_PHASE_MAX_CYC(bit_max_cyc), .ACK_HOLD_CYC(ack_cyc)) dut_u (.CLK(CLK), .RESETN(RESETN),
    .SUPPLY_OK(SUPPLY_OK), .CHIP_ON_PIN(CHIP_ON_PIN), .PWM_PIN(PWM_PIN), .ACK_PULL_O(ACK_PULL_O),
    .ACK_PULL_OE(ACK_PULL_OE), .DEVICE_ENABLED(DEVICE_ENABLED), .ONE_WIRE_MODE(ONE_WIRE_MODE),
    .PWM_MODE(PWM_MODE), .BRIGHTNESS_CODE(BRIGHTNESS_CODE), .CURRENT_LEVEL(CURRENT_LEVEL),
    .CMD_REJECTED(CMD_REJECTED));
  // Flags and hang guard
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (ACK_PULL_OE === 1'b1) ack_seen = 1'b1;
    if (CMD_REJECTED === 1'b1) rej_seen = 1'b1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  // Command word: address, ack flag at 10, code in 8..0, unused bits zero
  function [23:0] mk(input [7:0] a, input f, input [8:0] c);
    mk = {a, 5'h00, f, 1'b0, c};
  endfunction
  task conclude;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task t_start;
    begin
      `CHK("code", 9'h1FF, BRIGHTNESS_CODE)
      PWM_PIN <= 1'b0;
      host_u.hold(1'b1, 100);
      `CHK("en", 1'b0, DEVICE_ENABLED)
      host_u.hold(1'b0, 10);
      PWM_PIN <= 1'b1;
      host_u.detect;
      `CHK("ow", 1'b1, ONE_WIRE_MODE)
      `CHK("lvl", 9'h1FF, CURRENT_LEVEL)
      $display("start done");
    end
  endtask
  task t_cmd(input [7:0] a, input f, input [8:0] c, input [8:0] e, input r);
    begin
      ack_seen = 1'b0;
      rej_seen = 1'b0;
      host_u.frame(mk(a, f, c));
      `CHK("code", e, BRIGHTNESS_CODE)
      `CHK("lvl", e, CURRENT_LEVEL)
      `CHK("ack", f & ~r, ack_seen)
      `CHK("rej", r, rej_seen)
      $display("cmd done");
    end
  endtask
  task t_off;
    begin
      host_u.bits(mk(8'hA5, 1'b0, 9'h0F0), 10);
      host_u.hold(1'b1, 150);
      `CHK("partial", 9'h001, BRIGHTNESS_CODE)
      host_u.hold(1'b0, 400);
      `CHK("en", 1'b1, DEVICE_ENABLED)
      host_u.hold(1'b1, 20);
      host_u.hold(1'b0, 600);
      `CHK("en", 1'b0, DEVICE_ENABLED)
      `CHK("code", 9'h1FF, BRIGHTNESS_CODE)
      $display("off done");
    end
  endtask
  task t_pwm;
    begin
      host_u.hold(1'b1, 310);
      `CHK("pwm", 1'b1, PWM_MODE)
      `CHK("ow", 1'b0, ONE_WIRE_MODE)
      `CHK("lvl", 9'h1FF, CURRENT_LEVEL)
      repeat (12) begin
        PWM_PIN <= 1'b1;
        repeat (16) @(posedge CLK);
        PWM_PIN <= 1'b0;
        repeat (48) @(posedge CLK);
      end
      PWM_PIN <= 1'b1;
      repeat (15) @(posedge CLK);
      `CHK("duty", 9'h080, CURRENT_LEVEL)
      PWM_PIN <= 1'b0;
      repeat (1900) @(posedge CLK);
      `CHK("en", 1'b1, DEVICE_ENABLED)
      repeat (200) @(posedge CLK);
      `CHK("en", 1'b0, DEVICE_ENABLED)
      $display("pwm done");
    end
  endtask
  task t_supply;
    begin
      PWM_PIN <= 1'b1;
      repeat (260) @(posedge CLK);
      `CHK("pwm", 1'b1, PWM_MODE)
      `CHK("lvl", 9'h1FF, CURRENT_LEVEL)
      SUPPLY_OK <= 1'b0;
      repeat (6) @(posedge CLK);
      `CHK("en", 1'b0, DEVICE_ENABLED)
      `CHK("lvl", 9'h000, CURRENT_LEVEL)
      SUPPLY_OK <= 1'b1;
      $display("supply done");
    end
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    t_start;
    t_cmd(8'hA5, 1'b1, 9'h15A, 9'h15A, 1'b0);
    t_cmd(8'hA5, 1'b0, 9'h001, 9'h001, 1'b0);
    t_cmd(8'h25, 1'b1, 9'h0F0, 9'h001, 1'b1);
    t_off;
    t_pwm;
    t_supply;
    conclude;
  end
endmodule // tb
